// file: hw/rsoc_codec.sv
// Behaviour
// - transmit bits are scrambled before block coding
// - scrambler disabled passes transmit bits unaltered
// - scrambled bits are packed into 8-bit words
// - transmit FIFO decouples input and coded rates
// - k data bytes followed by 2t check bytes
// - codewords interleaved to depth four
// - a four-byte unique word ends each interleaved page
// - interleaved bytes leave serially toward host
// - receive bits packed and de-interleaved, depth four
// - unique words lock page; reorder only when locked
// - decoder recomputes checks and corrects data bytes
// - receive buffer passes only k data bytes
// - receive bytes descrambled whole, then reserialized
// - descrambler restores bits, aligned to page lock
`timescale 1ns/100ps
module rsoc_codec (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// code configuration, shared by both directions
	input wire rsoc_pkg::rsoc_cfg_type cfg,
	// transmit serial in from host, pin timing
	input wire logic txSerialIn,
	input wire logic txSerialClk,
	// transmit coded serial out
	output logic txOutBit,
	output logic txOutValid,
	input wire logic txOutReady,
	output logic txOverrun,
	// receive coded serial in, pin timing
	input wire logic rxSerialIn,
	input wire logic rxSerialClk,
	// receive user serial out
	output logic rxOutBit,
	output logic rxOutValid,
	input wire logic rxOutReady,
	// receive status
	output logic rxSynced,
	output logic rxCorrected,
	output logic rxUncorrectable
);
	rsoc_pkg::rsoc_state_type q;
	rsoc_pkg::rsoc_state_type d;

	// one page bank per half, rows of 256 byte columns
	logic [7:0] txMem [0:2047];
	logic [7:0] rxMem [0:2047];
	logic txWe;
	logic [10:0] txWa;
	logic [7:0] txWd;
	logic rxWe;
	logic [10:0] rxWa;
	logic [7:0] rxWd;

	// buffer handshakes
	logic txPush;
	logic txFifoInRdy;
	logic [7:0] txFifoInData;
	logic txFifoOutVal;
	logic txFifoOutRdy;
	logic [7:0] txFifoOutData;
	logic bufInVal;
	logic bufInRdy;
	logic [7:0] bufInData;
	logic bufOutVal;
	logic bufOutRdy;
	logic [7:0] bufOutData;

	// ----------------------------------------------------------------
	// buffers
	// ----------------------------------------------------------------
	// a full transmit fifo drops the byte and raises txOverrun
	rsoc_fifo #(.WIDTH(8), .DEPTH(rsoc_pkg::TX_FIFO_DEPTH)) txFifo (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.inValid(txPush),
		.inReady(txFifoInRdy),
		.inData(txFifoInData),
		.outValid(txFifoOutVal),
		.outReady(txFifoOutRdy),
		.outData(txFifoOutData)
	);

	// two-entry buffer; a stalled reader holds the decoder in DEC_OUT
	rsoc_fifo #(.WIDTH(8), .DEPTH(rsoc_pkg::RX_BUF_DEPTH)) rxBuf (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.inValid(bufInVal),
		.inReady(bufInRdy),
		.inData(bufInData),
		.outValid(bufOutVal),
		.outReady(bufOutRdy),
		.outData(bufOutData)
	);

	// ----------------------------------------------------------------
	// outputs, all straight from state
	// ----------------------------------------------------------------
	assign txOutBit = q.txShift[7];
	assign txOutValid = q.txLeft != 4'h0;
	assign txOverrun = q.txOverrun;
	assign rxOutBit = q.rxShift[7];
	assign rxOutValid = q.rxLeft != 4'h0;
	assign rxSynced = q.synced;
	assign rxCorrected = q.corr;
	assign rxUncorrectable = q.uncorr;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [4:0] twoT;
		logic [3:0] chkTop;
		logic [7:0] kLen;
		logic [10:0] pageLen;
		logic [rsoc_pkg::CHK_MAX:0][7:0] g;
		logic [7:0] fb;
		logic [7:0] a;
		logic [7:0] rxRd;
		logic [7:0] ob;
		logic [14:0] st;
		logic [31:0] win;
		logic sb;
		logic txEdge;
		logic rxEdge;
		logic hit;
		twoT = {cfg.t, 1'b0};
		chkTop = 4'(twoT - 5'h01);
		kLen = 8'(cfg.n - {3'h0, twoT});
		pageLen = {1'b0, cfg.n, 2'b00};
		g = rsoc_pkg::genPoly(twoT);
		fb = 8'h00;
		a = rsoc_pkg::GF_ONE;
		ob = 8'h00;
		st = q.dscr;
		win = q.rxWin;
		sb = 1'b0;
		hit = 1'b0;
		d = q;
		d.txOverrun = 1'b0;
		d.corr = 1'b0;
		d.uncorr = 1'b0;
		txPush = 1'b0;
		txWe = 1'b0;
		txWa = {q.encBank, q.encRow, q.encCol};
		txWd = txFifoOutData;
		rxWe = 1'b0;
		rxWa = {q.wrBank, q.rxCnt[1:0], q.rxCnt[9:2]};
		rxWd = 8'h00;
		rxRd = rxMem[{q.decBank, q.decRow, q.decIdx}];
		bufInVal = 1'b0;
		bufInData = 8'h00;
		bufOutRdy = 1'b0;

		// pins pass two flops, the clocks a third; stages two and three feed the edge finder
		d.txClkSync = {q.txClkSync[1:0], txSerialClk};
		d.txDatSync = {q.txDatSync[0], txSerialIn};
		d.rxClkSync = {q.rxClkSync[1:0], rxSerialClk};
		d.rxDatSync = {q.rxDatSync[0], rxSerialIn};
		txEdge = q.txClkSync[1] && !q.txClkSync[2];
		rxEdge = q.rxClkSync[1] && !q.rxClkSync[2];

		// transmit: scramble and pack on each host bit clock edge
		if (txEdge)
		begin
			sb = q.txDatSync[1];
			if (cfg.scrambleEn)
				sb = sb ^ q.scr[rsoc_pkg::SCR_TAP_A] ^ q.scr[rsoc_pkg::SCR_TAP_B];
			d.scr = {q.scr[13:0], sb};
			d.txAsm = {q.txAsm[5:0], sb};
			d.txAsmCnt = q.txAsmCnt + 3'h1;
			txPush = q.txAsmCnt == 3'h7;
		end
		txFifoInData = {q.txAsm, sb};
		if (txPush && !txFifoInRdy)
			d.txOverrun = 1'b1;

		// transmit: column-wise page read, then the unique-word trailer
		if (q.pgFull[q.rdBank] && q.txLeft == 4'h0)
		begin
			if (q.rdCnt < pageLen)
				d.txShift = txMem[{q.rdBank, q.rdCnt[1:0], q.rdCnt[9:2]}];
			else
				d.txShift = rsoc_pkg::UNIQUE_WORD[q.rdCnt[1:0]];
			d.txLeft = 4'h8;
			d.rdCnt = q.rdCnt + 11'h001;
			if (q.rdCnt == pageLen + rsoc_pkg::TRAILER_LAST)
			begin
				d.rdCnt = 11'h000;
				d.pgFull[q.rdBank] = 1'b0;
				d.rdBank = ~q.rdBank;
			end
		end
		else if (txOutValid && txOutReady)
		begin
			d.txShift = {q.txShift[6:0], 1'b0};
			d.txLeft = q.txLeft - 4'h1;
		end

		// transmit: encoder writes one codeword per row of the bank
		txFifoOutRdy = q.enc == rsoc_pkg::ENC_DATA && !q.pgFull[q.encBank];
		if (txFifoOutRdy && txFifoOutVal)
		begin
			txWe = 1'b1;
			fb = txFifoOutData ^ q.par[chkTop];
			for (int i = 0; i < rsoc_pkg::CHK_MAX; i++)
				d.par[i] = (i < int'(twoT)) ?
					((i > 0 ? q.par[i-1] : 8'h00) ^ rsoc_pkg::gfMul(fb, g[i])) : 8'h00;
			d.encCol = q.encCol + 8'h01;
			if (q.encCol == kLen - 8'h01)
				d.enc = rsoc_pkg::ENC_PARITY;
		end
		else if (q.enc == rsoc_pkg::ENC_PARITY)
		begin
			txWe = 1'b1;
			txWd = q.par[chkTop];
			for (int i = 0; i < rsoc_pkg::CHK_MAX; i++)
				d.par[i] = i > 0 ? q.par[i-1] : 8'h00;
			d.encCol = q.encCol + 8'h01;
			if (q.encCol == cfg.n - 8'h01)
			begin
				d.encCol = 8'h00;
				d.enc = rsoc_pkg::ENC_DATA;
				d.encRow = q.encRow + 2'h1;
				if (q.encRow == rsoc_pkg::LAST_ROW)
				begin
					d.pgFull[q.encBank] = 1'b1;
					d.encBank = ~q.encBank;
				end
			end
		end

		// receive: decoder works row by row on a finished page bank
		case (q.dec)
			rsoc_pkg::DEC_IDLE:
			begin
				if (q.pgReady[q.decBank])
				begin
					d.dec = rsoc_pkg::DEC_SYND;
					d.decRow = 2'h0;
					d.decIdx = 8'h00;
					d.syn = '0;
				end
			end
			rsoc_pkg::DEC_SYND:
			begin
				for (int i = 0; i < rsoc_pkg::CHK_MAX; i++)
				begin
					d.syn[i] = (i < int'(twoT)) ? (rsoc_pkg::gfMul(q.syn[i], a) ^ rxRd) : 8'h00;
					a = rsoc_pkg::gfMul(a, rsoc_pkg::GF_ALPHA);
				end
				d.decIdx = q.decIdx + 8'h01;
				if (q.decIdx == cfg.n - 8'h01)
				begin
					d.dec = rsoc_pkg::DEC_SEARCH;
					d.srchP = rsoc_pkg::GF_ONE;
					d.srchD = 8'h00;
				end
			end
			rsoc_pkg::DEC_SEARCH:
			begin
				// one candidate position per cycle; corrects a single byte
				hit = q.syn[0] != 8'h00;
				for (int i = 1; i < rsoc_pkg::CHK_MAX; i++)
					if (i < int'(twoT) && q.syn[i] != rsoc_pkg::gfMul(q.syn[i-1], q.srchP))
						hit = 1'b0;
				d.decIdx = 8'h00;
				d.errFound = 1'b0;
				d.dec = rsoc_pkg::DEC_OUT;
				if (q.syn == '0)
					d.errFound = 1'b0;
				else if (hit)
				begin
					d.errFound = 1'b1;
					d.errIdx = cfg.n - 8'h01 - q.srchD;
					d.corr = 1'b1;
				end
				else if (q.srchD == cfg.n - 8'h01)
					d.uncorr = 1'b1;
				else
				begin
					d.dec = rsoc_pkg::DEC_SEARCH;
					d.srchP = rsoc_pkg::gfMul(q.srchP, rsoc_pkg::GF_ALPHA);
					d.srchD = q.srchD + 8'h01;
				end
			end
			rsoc_pkg::DEC_OUT:
			begin
				bufInVal = 1'b1;
				bufInData = rxRd ^ ((q.errFound && q.decIdx == q.errIdx) ? q.syn[0] : 8'h00);
				if (bufInRdy)
				begin
					d.decIdx = q.decIdx + 8'h01;
					if (q.decIdx == kLen - 8'h01)
					begin
						d.decIdx = 8'h00;
						d.syn = '0;
						d.decRow = q.decRow + 2'h1;
						d.dec = rsoc_pkg::DEC_SYND;
						if (q.decRow == rsoc_pkg::LAST_ROW)
						begin
							d.pgReady[q.decBank] = 1'b0;
							d.decBank = ~q.decBank;
							d.dec = rsoc_pkg::DEC_IDLE;
						end
					end
				end
			end
			default:
				d.dec = rsoc_pkg::DEC_IDLE;
		endcase

		// receive: bit-level unique-word hunt gives byte and page lock
		if (rxEdge)
		begin
			win = {q.rxWin[30:0], q.rxDatSync[1]};
			d.rxWin = win;
			if (win == rsoc_pkg::UNIQUE_WORD)
			begin
				if (q.synced && q.rxBitCnt == 3'h7 &&
					q.rxCnt == pageLen + rsoc_pkg::TRAILER_LAST)
				begin
					d.pgReady[q.wrBank] = 1'b1;
					d.wrBank = ~q.wrBank;
				end
				d.synced = 1'b1;
				d.rxCnt = 11'h000;
				d.rxBitCnt = 3'h0;
			end
			else
			begin
				d.rxBitCnt = q.rxBitCnt + 3'h1;
				if (q.synced && q.rxBitCnt == 3'h7)
				begin
					rxWe = q.rxCnt < pageLen;
					rxWd = win[7:0];
					d.rxCnt = q.rxCnt + 11'h001;
					// a missing trailer drops lock and the page in progress
					if (q.rxCnt >= pageLen + rsoc_pkg::TRAILER_LAST)
						d.synced = 1'b0;
				end
			end
		end

		// receive: reserialize and descramble a whole byte at load time
		if (q.rxLeft == 4'h0 && bufOutVal)
		begin
			bufOutRdy = 1'b1;
			for (int b = 7; b >= 0; b--)
			begin
				ob[b] = bufOutData[b];
				if (cfg.descrambleEn)
					ob[b] = ob[b] ^ st[rsoc_pkg::SCR_TAP_A] ^ st[rsoc_pkg::SCR_TAP_B];
				st = {st[13:0], bufOutData[b]};
			end
			d.rxShift = ob;
			d.dscr = st;
			d.rxLeft = 4'h8;
		end
		else if (rxOutValid && rxOutReady)
		begin
			d.rxShift = {q.rxShift[6:0], 1'b0};
			d.rxLeft = q.rxLeft - 4'h1;
		end
		// descrambler restarts from zero until the page lock returns
		if (!q.synced)
			d.dscr = '0;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			q <= rsoc_pkg::STATE_RESET;
		else if (ce)
			q <= d;
	end

	// page memories hold data only, no reset needed
	always_ff @(posedge clk)
	begin
		if (ce && txWe)
			txMem[txWa] <= txWd;
		if (ce && rxWe)
			rxMem[rxWa] <= rxWd;
	end
endmodule : rsoc_codec

// file: hw/rsoc_pkg.sv
package rsoc_pkg;

	// ----------------------------------------------------------------
	// code geometry and buffering
	// ----------------------------------------------------------------
	localparam int T_MAX = 8;
	localparam int CHK_MAX = 2 * T_MAX;
	localparam int TX_FIFO_DEPTH = 16;
	localparam int RX_BUF_DEPTH = 2;
	localparam logic [1:0] LAST_ROW = 2'h3;
	localparam logic [10:0] TRAILER_LAST = 11'h003;
	localparam logic [7:0] GF_POLY = 8'h1d;
	localparam logic [7:0] GF_ONE = 8'h01;
	localparam logic [7:0] GF_ALPHA = 8'h02;
	// page trailer, first byte sent first; value is a plain default
	localparam logic [0:3][7:0] UNIQUE_WORD = {8'h1a, 8'hcf, 8'hfc, 8'h1d};

	// ----------------------------------------------------------------
	// scrambler: 15-stage register, feedback from stages 14 and 15
	// ----------------------------------------------------------------
	localparam int SCR_TAP_A = 13;
	localparam int SCR_TAP_B = 14;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] n;
		logic [3:0] t;
		logic scrambleEn;
		logic descrambleEn;
	} rsoc_cfg_type;

	typedef enum logic {ENC_DATA = 1'b0, ENC_PARITY = 1'b1} rsoc_enc_type;

	typedef enum logic [1:0] {
		DEC_IDLE = 2'b00,
		DEC_SYND = 2'b01,
		DEC_SEARCH = 2'b10,
		DEC_OUT = 2'b11
	} rsoc_dec_type;

	typedef struct packed {
		logic [2:0] txClkSync;
		logic [1:0] txDatSync;
		logic [14:0] scr;
		logic [6:0] txAsm;
		logic [2:0] txAsmCnt;
		logic txOverrun;
		rsoc_enc_type enc;
		logic encBank;
		logic [1:0] encRow;
		logic [7:0] encCol;
		logic [CHK_MAX-1:0][7:0] par;
		logic [1:0] pgFull;
		logic rdBank;
		logic [10:0] rdCnt;
		logic [7:0] txShift;
		logic [3:0] txLeft;
		logic [2:0] rxClkSync;
		logic [1:0] rxDatSync;
		logic [31:0] rxWin;
		logic synced;
		logic [2:0] rxBitCnt;
		logic [10:0] rxCnt;
		logic wrBank;
		logic [1:0] pgReady;
		rsoc_dec_type dec;
		logic decBank;
		logic [1:0] decRow;
		logic [7:0] decIdx;
		logic [CHK_MAX-1:0][7:0] syn;
		logic [7:0] srchP;
		logic [7:0] srchD;
		logic errFound;
		logic [7:0] errIdx;
		logic corr;
		logic uncorr;
		logic [7:0] rxShift;
		logic [3:0] rxLeft;
		logic [14:0] dscr;
	} rsoc_state_type;

	localparam rsoc_state_type STATE_RESET = '0;

	// ----------------------------------------------------------------
	// galois field arithmetic over GF(256)
	// ----------------------------------------------------------------
	function automatic logic [7:0] gfMul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++)
		begin
			if (b[i])
				p = p ^ x;
			x = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY : 8'h00);
		end
		return p;
	endfunction : gfMul

	// generator with roots alpha^0 .. alpha^(2t-1)
	function automatic logic [CHK_MAX:0][7:0] genPoly(input logic [4:0] twoT);
		logic [CHK_MAX:0][7:0] g;
		logic [7:0] a;
		g = '0;
		g[0] = GF_ONE;
		a = GF_ONE;
		for (int j = 0; j < CHK_MAX; j++)
		begin
			if (j < int'(twoT))
			begin
				for (int i = CHK_MAX; i > 0; i--)
					g[i] = g[i-1] ^ gfMul(g[i], a);
				g[0] = gfMul(g[0], a);
			end
			a = gfMul(a, GF_ALPHA);
		end
		return g;
	endfunction : genPoly

endpackage : rsoc_pkg

// file: hw/rsoc_fifo.sv
`timescale 1ns/100ps
module rsoc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] cnt;
	} rsoc_fifo_state_type;

	rsoc_fifo_state_type q;
	rsoc_fifo_state_type d;
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic push;
	logic pop;

	// ----------------------------------------------------------------
	// flags; pointers wrap naturally, so depth must be a power of two
	// ----------------------------------------------------------------
	assign inReady = q.cnt != (AW+1)'(DEPTH);
	assign outValid = q.cnt != '0;
	assign outData = mem[q.rd];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// pointer and fill count update
	always_comb
	begin
		d = q;
		if (push)
			d.wr = q.wr + AW'(1);
		if (pop)
			d.rd = q.rd + AW'(1);
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			q <= '0;
		else if (ce)
			q <= d;
	end

	// storage needs no reset, nothing reads an empty slot
	always_ff @(posedge clk)
	begin
		if (ce && push)
			mem[q.wr] <= inData;
	end
endmodule : rsoc_fifo

// file: tb/rsoc_codec_properties.sv
`timescale 1ns/100ps
module rsoc_codec_properties (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// configuration and link pins
	input wire rsoc_pkg::rsoc_cfg_type cfg,
	input wire logic txSerialIn,
	input wire logic txSerialClk,
	input wire logic rxSerialIn,
	input wire logic rxSerialClk,
	// coded transmit output
	input wire logic txOutBit,
	input wire logic txOutValid,
	input wire logic txOutReady,
	input wire logic txOverrun,
	// user receive output and status
	input wire logic rxOutBit,
	input wire logic rxOutValid,
	input wire logic rxOutReady,
	input wire logic rxSynced,
	input wire logic rxCorrected,
	input wire logic rxUncorrectable
);
	// ----------------------------------------------------------------
	// helper state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] txTaken;
		logic [2:0] rxTaken;
		logic txClkPrev;
		logic rxClkPrev;
		logic [3:0] rxSince;
		logic everSynced;
		logic [15:0] txEdges;
	} rsoc_chk_type;
	rsoc_chk_type chk_q;
	rsoc_chk_type chk_d;
	logic txTake;
	logic rxTake;
	assign txTake = txOutValid && txOutReady;
	assign rxTake = rxOutValid && rxOutReady;
	// bit position in byte, link clock edges seen at the pins; edge counters saturate, bit positions wrap
	always_comb
	begin
		chk_d = chk_q;
		chk_d.txTaken = chk_q.txTaken + 3'(txTake);
		chk_d.rxTaken = chk_q.rxTaken + 3'(rxTake);
		chk_d.txClkPrev = txSerialClk;
		chk_d.rxClkPrev = rxSerialClk;
		chk_d.everSynced = chk_q.everSynced || rxSynced;
		if (rxSerialClk && !chk_q.rxClkPrev)
			chk_d.rxSince = 4'h0;
		else if (chk_q.rxSince != 4'hf)
			chk_d.rxSince = chk_q.rxSince + 4'h1;
		if (txSerialClk && !chk_q.txClkPrev && chk_q.txEdges != 16'hffff)
			chk_d.txEdges = chk_q.txEdges + 16'h0001;
	end
	// helper register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			chk_q <= '0;
		else
			chk_q <= chk_d;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_RESET_QUIET: assert property ($rose(reset_n) |->
		!(txOutValid || rxOutValid || rxSynced || txOverrun || rxCorrected || rxUncorrectable))
		else $error("output active at reset release");
	AST_TX_HOLD: assert property (txOutValid && !txOutReady |=>
		txOutValid && $stable(txOutBit)) else $error("coded bit changed while stalled");
	AST_RX_HOLD: assert property (rxOutValid && !rxOutReady |=>
		rxOutValid && $stable(rxOutBit)) else $error("user bit changed while stalled");
	AST_TX_FLOW: assert property (txTake |=>
		txOutValid == ($past(chk_q.txTaken) != 3'h7)) else $error("coded byte pacing wrong");
	AST_RX_FLOW: assert property (rxTake |=>
		rxOutValid == ($past(chk_q.rxTaken) != 3'h7)) else $error("user byte pacing wrong");
	AST_STATUS_PULSE: assert property (rxCorrected || rxUncorrectable |->
		(rxCorrected != rxUncorrectable) ##1 !(rxCorrected || rxUncorrectable))
		else $error("block status pulse malformed");
	AST_LOCK_TIMING: assert property ($rose(rxSynced) |->
		chk_q.rxSince inside {[4'h1:4'h6]}) else $error("lock not tied to a link edge");
	AST_RX_AFTER_LOCK: assert property (rxOutValid |-> chk_q.everSynced)
		else $error("user data before lock");
	AST_TX_AFTER_PAGE: assert property (txOutValid |->
		int'(chk_q.txEdges) >= 32 * (int'(cfg.n) - 2 * int'(cfg.t)))
		else $error("coded output before a full page of input");
endmodule : rsoc_codec_properties

bind rsoc_codec rsoc_codec_properties rsoc_codec_properties_i (.clk, .reset_n, .ce, .cfg,
	.txSerialIn, .txSerialClk, .rxSerialIn, .rxSerialClk, .txOutBit, .txOutValid,
	.txOutReady, .txOverrun, .rxOutBit, .rxOutValid, .rxOutReady, .rxSynced,
	.rxCorrected, .rxUncorrectable);

// file: tb/rsoc_host_model.sv
`timescale 1ns/100ps
module rsoc_host_model (
	// clock and take policy
	input wire logic clk,
	input wire logic readyHint,
	// user link toward the codec
	output logic txSerialIn,
	output logic txSerialClk,
	// coded stream from the codec
	input wire logic txOutBit,
	input wire logic txOutValid,
	output logic txOutReady,
	// coded stream looped back
	output logic rxSerialIn,
	output logic rxSerialClk
);
	logic txBits[$];
	logic loopBits[$];
	logic [7:0] flipMask[int];
	int takenBits = 0;
	int txPh = 0;
	int rxPh = 0;
	// ----------------------------------------------------------------
	// user side
	// ----------------------------------------------------------------
	task automatic sendByte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			txBits.push_back(b[i]);
	endtask : sendByte
	// called under reset so no half-sent bit survives into the next run
	task automatic restart();
		takenBits = 0;
		flipMask.delete();
		txBits.delete();
		loopBits.delete();
	endtask : restart
	// bit set up with clock low; clock stands still and data wanders between frames
	always @(posedge clk)
	begin
		txOutReady <= readyHint;
		if (txOutValid && txOutReady)
			loopBits.push_back(txOutBit ^ (flipMask.exists(takenBits / 8) ?
				flipMask[takenBits / 8][7 - takenBits % 8] : 1'b0));
		if (txOutValid && txOutReady)
			takenBits++;
		if (txPh inside {[1:7]})
			txPh++;
		else if (txBits.size() > 0)
		begin
			txSerialIn <= txBits.pop_front();
			txPh = 1;
		end
		else
		begin
			txSerialIn <= ~txSerialIn;
			txPh = 0;
		end
		txSerialClk <= (txPh >= 5);
		if (rxPh inside {[1:7]})
			rxPh++;
		else if (loopBits.size() > 0)
		begin
			rxSerialIn <= loopBits.pop_front();
			rxPh = 1;
		end
		else
		begin
			rxSerialIn <= ~rxSerialIn;
			rxPh = 0;
		end
		rxSerialClk <= (rxPh >= 5);
	end
	initial
	begin
		txSerialIn = 1'b0;
		txSerialClk = 1'b0;
		txOutReady = 1'b0;
		rxSerialIn = 1'b0;
		rxSerialClk = 1'b0;
	end
endmodule : rsoc_host_model

// file: tb/rsoc_codec_tb_top.sv
`timescale 1ns/100ps
module rsoc_codec_tb_top;
	logic clk, reset_n, ce, readyHint;
	rsoc_pkg::rsoc_cfg_type cfg;
	logic txSerialIn, txSerialClk, txOutBit, txOutValid, txOutReady, txOverrun;
	logic rxSerialIn, rxSerialClk, rxOutBit, rxOutValid, rxOutReady;
	logic rxSynced, rxCorrected, rxUncorrectable;
	int mismatches = 0;
	int checked = 0;
	int n, k, txBytes, txBitCnt, corrCnt, uncCnt, ovrCnt, rxSkip;
	logic [31:0] rnd = 32'heede;
	logic [31:0] rndRdy = 32'heede;
	logic [14:0] scr;
	logic scrOn;
	logic [7:0] txAcc;
	logic [7:0] txExp[$];
	logic rxExp[$];
	logic [7:0] corner[4] = '{8'h00, 8'hff, 8'h80, 8'h01};

	rsoc_codec rsoc_codec_i (.clk, .reset_n, .ce, .cfg, .txSerialIn, .txSerialClk, .txOutBit,
		.txOutValid, .txOutReady, .txOverrun, .rxSerialIn, .rxSerialClk, .rxOutBit,
		.rxOutValid, .rxOutReady, .rxSynced, .rxCorrected, .rxUncorrectable);
	rsoc_host_model rsoc_host_model_i (.clk, .readyHint, .txSerialIn, .txSerialClk,
		.txOutBit, .txOutValid, .txOutReady, .rxSerialIn, .rxSerialClk);

	always #50 clk = ~clk;

	// ----------------------------------------------------------------
	// expectation helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	// register fed by its own output, so the far end locks without a reset
	function automatic logic [7:0] scramble(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			s = b[i] ^ (scrOn & (scr[rsoc_pkg::SCR_TAP_A] ^ scr[rsoc_pkg::SCR_TAP_B]));
			scr = {scr[13:0], s};
			b[i] = s;
		end
		return b;
	endfunction : scramble
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		if (mismatches == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	// coded byte place: rows read column by column, trailer after the page
	task automatic txPage(input logic [7:0] b);
		int p, j;
		p = txBytes / (4 * n + 4);
		j = txBytes % (4 * n + 4);
		txBytes++;
		if (j >= 4 * n)
			check(b, rsoc_pkg::UNIQUE_WORD[j - 4 * n]);
		else if (j / 4 < k)
			check(b, txExp[p * 4 * k + (j % 4) * k + j / 4]);
	endtask : txPage

	// ----------------------------------------------------------------
	// monitors and random stalls
	// ----------------------------------------------------------------
	always @(posedge clk)
	begin
		rndRdy = xs(rndRdy);
		rxOutReady <= rndRdy[0] & rndRdy[1];
		readyHint <= rndRdy[2] | rndRdy[3];
		corrCnt += int'(rxCorrected);
		uncCnt += int'(rxUncorrectable);
		ovrCnt += int'(txOverrun);
		if (txOutValid && txOutReady)
			txAcc = {txAcc[6:0], txOutBit};
		if (txOutValid && txOutReady && ++txBitCnt == 8)
			txPage(txAcc);
		if (txBitCnt == 8)
			txBitCnt = 0;
		if (rxOutValid && rxOutReady && rxSkip > 0)
			void'(rxExp.pop_front());
		else if (rxOutValid && rxOutReady)
			check({7'h0, rxOutBit}, rxExp.size() > 0 ? {7'h0, rxExp.pop_front()} : 8'hxx);
		if (rxOutValid && rxOutReady && rxSkip > 0)
			rxSkip--;
	end

	// ----------------------------------------------------------------
	// one run: four pages through the loop, one fixed and one hopeless block
	// ----------------------------------------------------------------
	task automatic runCodec(input logic [7:0] cn, input logic [3:0] ct, input logic en);
		int w;
		logic [7:0] b;
		reset_n <= 1'b0;
		cfg <= '{n: cn, t: ct, scrambleEn: en, descrambleEn: en};
		n = int'(cn);
		k = n - 2 * int'(ct);
		scrOn = en;
		scr = '0;
		txBytes = 0;
		txBitCnt = 0;
		corrCnt = 0;
		uncCnt = 0;
		ovrCnt = 0;
		rxSkip = en ? 15 : 0;
		txExp.delete();
		rxExp.delete();
		rsoc_host_model_i.restart();
		rsoc_host_model_i.flipMask[2 * (4 * n + 4)] = 8'h5a;
		rsoc_host_model_i.flipMask[3 * (4 * n + 4) + 1 + 4 * k] = 8'h81;
		rsoc_host_model_i.flipMask[3 * (4 * n + 4) + 5 + 4 * k] = 8'h3c;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 16 * k; i++)
		begin
			rnd = xs(rnd);
			b = (i < 4) ? corner[i] : rnd[7:0];
			txExp.push_back(scramble(b));
			for (int j = 7; j >= 0 && i >= 4 * k; j--)
				rxExp.push_back(b[j]);
			rsoc_host_model_i.sendByte(b);
		end
		for (w = 0; w < 40000 && rxExp.size() > 0; w++)
			@(posedge clk);
		if (rxExp.size() > 0)
			mismatches++;
		if (rxExp.size() > 0)
			tally_and_finish();
		repeat (50) @(posedge clk);
		check(8'(corrCnt), 8'h01);
		check(8'(uncCnt), 8'h01);
		check({7'h0, rxSynced}, 8'h01);
		check(8'(ovrCnt), 8'h00);
		check(8'(txBytes / (4 * n + 4)), 8'h04);
	endtask : runCodec

	initial
	begin
		clk = 1'b0;
		reset_n = 1'b0;
		ce = 1'b1;
		cfg = '0;
		readyHint = 1'b0;
		rxOutReady = 1'b0;
		runCodec(8'h0c, 4'h2, 1'b0);
		runCodec(8'h10, 4'h3, 1'b1);
		tally_and_finish();
	end
endmodule : rsoc_codec_tb_top
